// [logic/ssx_pkg.sv]
package ssx_pkg;

   // ************************************************************
   // Shift timing
   // ************************************************************
   localparam int DIV_RATIO = 12;
   localparam int HALF_RATIO = DIV_RATIO / 2;
   localparam int FRAME_BITS = 8;

   // ************************************************************
   // Register map, byte addresses
   // ************************************************************
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_BUF = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_STAT = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_MASK = 12'h00c;

   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int CTRL_RI_BIT = 0;
   localparam int CTRL_TI_BIT = 1;
   localparam int CTRL_REN_BIT = 4;
   localparam int CTRL_MODE_LSB = 6;
   localparam int MODE_W = 2;
   localparam logic [MODE_W-1:0] MODE_SYNC = 2'h0;
   localparam logic [MODE_W-1:0] MODE_RST = 2'h0;

   // ************************************************************
   // Interrupt fields
   // ************************************************************
   localparam int IRQ_W = 2;
   localparam int IRQ_RX_BIT = 0;
   localparam int IRQ_TX_BIT = 1;
   localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

   typedef enum logic [1:0] {
      SSX_IDLE,
      SSX_TX,
      SSX_RX
   } ssx_state_e;

endpackage

// [logic/ssx_sync3.sv]
`timescale 1ns/1ps
module ssx_sync3 (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);

   logic ff1;
   logic ff2;
   logic ff3;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ff1 <= 1'b0;
         ff2 <= 1'b0;
         ff3 <= 1'b0;
      end else begin
         ff1 <= async_i;
         ff2 <= ff1;
         ff3 <= ff2;
      end
   end

   // Change accepted only once the last two stages agree
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         sync_o <= 1'b0;
      end else if (ff2 == ff3) begin
         sync_o <= ff3;
      end
   end

endmodule

// [logic/ssx_expander.sv]
// Functional notes
// R1: Shift bit rate is clock divided by twelve
// R2: Data pin carries both directions of data
// R3: Shift clock is driven on clock pin
// R4: Eight bits per transfer, LSB first
// R5: Control write with receive enable starts reception
// R6: Receive done flag set; software clears it
// R7: Buffer write starts transmit; done flag set
// R8: Expander latches inputs while load low
// R9: Expander shifts only when enabled by load
// R10: No new transfer while a done flag set
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module ssx_expander #(
   parameter int DIV_RATIO = ssx_pkg::DIV_RATIO,
   parameter int FRAME_BITS = ssx_pkg::FRAME_BITS
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ssx_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic irq_o,
   output logic shift_clk_o,
   output logic data_o,
   output logic data_oe_n_o,
   input wire logic data_i
);

   localparam int HALF = DIV_RATIO / 2;
   localparam int CW = $clog2(DIV_RATIO);
   localparam int BW = $clog2(FRAME_BITS);
   localparam int FRAME_CYC = DIV_RATIO * FRAME_BITS;
   // ************************************************************
   // Registers and state
   // ************************************************************
   ssx_pkg::ssx_state_e state;
   logic [CW-1:0] div_cnt;
   logic [BW-1:0] bit_cnt;
   logic [FRAME_BITS-1:0] shreg;
   logic [FRAME_BITS-1:0] rx_data;
   logic [ssx_pkg::MODE_W-1:0] mode;
   logic rx_enable;
   logic receive_done_flag;
   logic transmit_done_flag;
   logic rx_done_p;
   logic tx_done_p;
   logic [ssx_pkg::IRQ_W-1:0] irq_stat;
   logic [ssx_pkg::IRQ_W-1:0] irq_mask;
   logic [ssx_pkg::IRQ_W-1:0] irq_ev;
   logic data_in_sync;

   ssx_sync3 u_sync (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .async_i(data_i),
      .sync_o(data_in_sync)
   );

   // ************************************************************
   // APB decode
   // ************************************************************
   logic acc_first;
   logic wr_fire;
   logic ctrl_wr;
   logic buf_wr;
   logic stat_wr;
   logic mask_wr;
   logic mapped;
   logic idle_ok;
   logic rx_start;
   logic tx_start;
   logic [ssx_pkg::MODE_W-1:0] wmode;
   logic [31:0] next_rdata;

   // Ready registered: every access takes one wait state
   assign acc_first = psel_i & penable_i & ~pready_o;
   assign wr_fire = psel_i & penable_i & pready_o & pwrite_i;
   assign ctrl_wr = wr_fire & (paddr_i == ssx_pkg::OFF_CTRL);
   assign buf_wr = wr_fire & (paddr_i == ssx_pkg::OFF_BUF);
   assign stat_wr = wr_fire & (paddr_i == ssx_pkg::OFF_STAT);
   assign mask_wr = wr_fire & (paddr_i == ssx_pkg::OFF_MASK);
   assign mapped = (paddr_i == ssx_pkg::OFF_CTRL) |
                   (paddr_i == ssx_pkg::OFF_BUF) |
                   (paddr_i == ssx_pkg::OFF_STAT) |
                   (paddr_i == ssx_pkg::OFF_MASK);
   assign wmode = pwdata_i[ssx_pkg::CTRL_MODE_LSB +: ssx_pkg::MODE_W];

   // Done pulse cycle counts as busy so the flag cannot be raced
   assign idle_ok = (state == ssx_pkg::SSX_IDLE) & ~rx_done_p &
                    ~tx_done_p;
   // Start only if this same write leaves both flags clear
   assign rx_start = ctrl_wr & idle_ok & (wmode == ssx_pkg::MODE_SYNC) &
                     pwdata_i[ssx_pkg::CTRL_REN_BIT] &
                     ~pwdata_i[ssx_pkg::CTRL_RI_BIT] &
                     ~pwdata_i[ssx_pkg::CTRL_TI_BIT]; // R5 R10
   assign tx_start = buf_wr & idle_ok & (mode == ssx_pkg::MODE_SYNC) &
                     ~receive_done_flag &
                     ~transmit_done_flag; // R7 R10

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr_i)
         ssx_pkg::OFF_CTRL: begin
            next_rdata[ssx_pkg::CTRL_MODE_LSB +: ssx_pkg::MODE_W] = mode;
            next_rdata[ssx_pkg::CTRL_REN_BIT] = rx_enable;
            next_rdata[ssx_pkg::CTRL_TI_BIT] = transmit_done_flag;
            next_rdata[ssx_pkg::CTRL_RI_BIT] = receive_done_flag;
         end
         ssx_pkg::OFF_BUF: next_rdata[FRAME_BITS-1:0] = rx_data;
         ssx_pkg::OFF_STAT: next_rdata[ssx_pkg::IRQ_W-1:0] = irq_stat;
         ssx_pkg::OFF_MASK: next_rdata[ssx_pkg::IRQ_W-1:0] = irq_mask;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= acc_first;
         if (acc_first) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
            pslverr_o <= ~mapped;
         end else begin
            pslverr_o <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Control register and done flags
   // ************************************************************
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         mode <= ssx_pkg::MODE_RST;
         rx_enable <= 1'b0;
      end else if (ctrl_wr) begin
         mode <= wmode;
         rx_enable <= pwdata_i[ssx_pkg::CTRL_REN_BIT];
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         receive_done_flag <= 1'b0;
         transmit_done_flag <= 1'b0;
      end else begin
         if (rx_done_p) begin
            receive_done_flag <= 1'b1; // R6
         end else if (ctrl_wr) begin
            receive_done_flag <= pwdata_i[ssx_pkg::CTRL_RI_BIT]; // R6
         end
         if (tx_done_p) begin
            transmit_done_flag <= 1'b1; // R7
         end else if (ctrl_wr) begin
            transmit_done_flag <= pwdata_i[ssx_pkg::CTRL_TI_BIT]; // R7
         end
      end
   end

   // ************************************************************
   // Interrupt status and mask
   // ************************************************************
   assign irq_ev[ssx_pkg::IRQ_RX_BIT] = rx_done_p;
   assign irq_ev[ssx_pkg::IRQ_TX_BIT] = tx_done_p;

   genvar gi;
   generate
      for (gi = 0; gi < ssx_pkg::IRQ_W; gi++) begin : g_irq
         always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
               irq_stat[gi] <= 1'b0;
            end else if (irq_ev[gi]) begin
               irq_stat[gi] <= 1'b1;
            end else if (stat_wr & pwdata_i[gi]) begin
               irq_stat[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_mask <= ssx_pkg::MASK_RST;
      end else if (mask_wr) begin
         irq_mask <= pwdata_i[ssx_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
      end
   end

   // ************************************************************
   // Shift engine
   // ************************************************************
   logic bit_mid;
   logic bit_end;
   logic last_bit;

   assign bit_mid = (div_cnt == CW'(HALF - 1));
   assign bit_end = (div_cnt == CW'(DIV_RATIO - 1));
   assign last_bit = (bit_cnt == BW'(FRAME_BITS - 1));

   // Clock low first half of each bit, high second half;
   // the expander shifts on the rising edge
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ssx_pkg::SSX_IDLE;
         div_cnt <= '0;
         bit_cnt <= '0;
         shreg <= '0;
         rx_data <= '0;
         shift_clk_o <= 1'b1;
         data_o <= 1'b0;
         data_oe_n_o <= 1'b1;
         rx_done_p <= 1'b0;
         tx_done_p <= 1'b0;
      end else begin
         rx_done_p <= 1'b0;
         tx_done_p <= 1'b0;
         unique case (state)
            ssx_pkg::SSX_IDLE: begin
               shift_clk_o <= 1'b1; // R3
               data_oe_n_o <= 1'b1;
               div_cnt <= '0;
               bit_cnt <= '0;
               if (tx_start) begin
                  state <= ssx_pkg::SSX_TX;
                  shreg <= pwdata_i[FRAME_BITS-1:0];
                  data_o <= pwdata_i[0]; // R4
                  data_oe_n_o <= 1'b0; // R2
                  shift_clk_o <= 1'b0; // R3
               end else if (rx_start) begin
                  state <= ssx_pkg::SSX_RX;
                  data_o <= 1'b0;
                  shift_clk_o <= 1'b0; // R3
               end
            end
            default: begin
               div_cnt <= div_cnt + CW'(1); // R1
               if (bit_mid) begin
                  shift_clk_o <= 1'b1; // R1
                  // Synchroniser delay keeps the sample inside the
                  // low half, before the expander moves its output
                  if (state == ssx_pkg::SSX_RX) begin
                     shreg <= {data_in_sync,
                               shreg[FRAME_BITS-1:1]}; // R2 R4
                  end
               end
               if (bit_end) begin
                  div_cnt <= '0;
                  if (last_bit) begin
                     state <= ssx_pkg::SSX_IDLE;
                     data_oe_n_o <= 1'b1;
                     if (state == ssx_pkg::SSX_RX) begin
                        rx_data <= shreg; // R6
                        rx_done_p <= 1'b1;
                     end else begin
                        tx_done_p <= 1'b1;
                     end
                  end else begin
                     bit_cnt <= bit_cnt + BW'(1); // R4
                     shift_clk_o <= 1'b0;
                     if (state == ssx_pkg::SSX_TX) begin
                        shreg <= {1'b0, shreg[FRAME_BITS-1:1]};
                        data_o <= shreg[1]; // R4
                     end
                  end
               end
            end
         endcase
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   logic [BW:0] rise_cnt;
   logic clk_q;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rise_cnt <= '0;
         clk_q <= 1'b1;
      end else begin
         clk_q <= shift_clk_o;
         if (tx_start | rx_start) begin
            rise_cnt <= '0;
         end else if (shift_clk_o & ~clk_q) begin
            rise_cnt <= rise_cnt + (BW+1)'(1);
         end
      end
   end

   a_low_half: assert property ( // R1
      $fell(shift_clk_o) |-> !shift_clk_o [*6] ##1 shift_clk_o)
      else $error("shift clock low phase not six cycles");
   a_high_half: assert property ( // R1
      $rose(shift_clk_o) && state != ssx_pkg::SSX_IDLE
      |-> shift_clk_o [*6])
      else $error("shift clock high phase too short");
   a_rx_released: assert property ( // R2
      state == ssx_pkg::SSX_RX |-> data_oe_n_o)
      else $error("data pin driven during reception");
   a_tx_driven: assert property ( // R2
      state == ssx_pkg::SSX_TX |-> !data_oe_n_o)
      else $error("data pin not driven during transmit");
   a_idle_clock: assert property ( // R3
      state == ssx_pkg::SSX_IDLE && $past(state) == ssx_pkg::SSX_IDLE
      |-> shift_clk_o)
      else $error("shift clock not high while idle");
   a_eight_edges: assert property ( // R4
      rx_done_p || tx_done_p |-> rise_cnt == (BW+1)'(FRAME_BITS))
      else $error("transfer did not carry eight clock edges");
   a_tx_lsb_first: assert property ( // R4
      tx_start |=> data_o == $past(pwdata_i[0]) && !shift_clk_o)
      else $error("first transmitted bit is not the lsb");
   a_rx_starts: assert property ( // R5
      rx_start |=> state == ssx_pkg::SSX_RX ##FRAME_CYC rx_done_p)
      else $error("reception did not run one frame");
   a_rx_flag_set: assert property ( // R6
      rx_done_p |=> receive_done_flag && irq_stat[ssx_pkg::IRQ_RX_BIT])
      else $error("receive done flag not set");
   a_tx_flag_set: assert property ( // R7
      tx_start |=> ##FRAME_CYC tx_done_p ##1 transmit_done_flag)
      else $error("transmit done flag not set after frame");
   a_flag_blocks: assert property ( // R10
      (receive_done_flag || transmit_done_flag) && buf_wr
      |=> state == ssx_pkg::SSX_IDLE)
      else $error("transfer started while done flag set");
   a_irq_level: assert property (
      |(irq_stat & irq_mask) |=> irq_o)
      else $error("interrupt not raised for unmasked status");

   c_rx_frame: cover property (rx_start ##(FRAME_CYC + 1) rx_done_p);
   c_tx_frame: cover property (tx_start ##(FRAME_CYC + 1) tx_done_p);
   c_blocked: cover property (buf_wr && transmit_done_flag);
   c_irq: cover property ($rose(irq_o));

endmodule

// [tb/ssx_partner.sv]
`timescale 1ns/1ps
// ********
// Expander chips at the far end of the shift link
// ********
module ssx_partner (
   input wire logic shift_clk_i,
   input wire logic pin_i,
   input wire logic load_n_i,
   input wire logic clk_dis_i,
   input wire logic [7:0] par_i,
   output logic ser_o,
   output logic [7:0] out_byte_o
);
   logic [7:0] sh;
   // Load is level sensitive and beats the clock
   always @(posedge shift_clk_i or negedge load_n_i) begin
      if (!load_n_i) begin
         sh <= par_i;
      end else if (!clk_dis_i) begin
         // Vacated bits carry inverse data so stale bits never match
         sh <= {~sh[0], sh[7:1]};
      end
   end
   assign ser_o = sh[0];
   always @(posedge shift_clk_i) begin
      out_byte_o <= {pin_i, out_byte_o[7:1]};
   end
endmodule

// [tb/serial_shift_io_expander_test.sv]
`timescale 1ns/1ps
module serial_shift_io_expander_test;
   typedef struct packed {logic wr; logic [31:0] d; logic e;} ssx_exp_s;
   localparam logic [11:0] A_CTRL = ssx_pkg::OFF_CTRL;
   localparam logic [11:0] A_BUF = ssx_pkg::OFF_BUF;
   localparam logic [11:0] A_STAT = ssx_pkg::OFF_STAT;
   localparam logic [11:0] A_MASK = ssx_pkg::OFF_MASK;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, sclk, dout, doe_n, pin, ser;
   logic load_n = 1'b1;
   logic clk_dis = 1'b1;
   logic [7:0] par = 8'h00;
   logic [7:0] obyte, b;
   logic drove = 1'b0;
   ssx_exp_s exp_q[$];
   ssx_exp_s e_now;
   int n_fail = 0;
   int comparisons = 0;
   int n_rise = 0;
   realtime t_rise = 0;

   always #5 mclk = ~mclk;
   // Pin owner follows the design's enable
   assign pin = doe_n ? ser : dout;

   ssx_expander uut (.mclk_i(mclk), .rst_i(rst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .irq_o(irq), .shift_clk_o(sclk),
      .data_o(dout), .data_oe_n_o(doe_n), .data_i(pin));
   ssx_partner model (.shift_clk_i(sclk), .pin_i(pin), .load_n_i(load_n),
      .clk_dis_i(clk_dis), .par_i(par), .ser_o(ser), .out_byte_o(obyte));

   // ********
   // Checking
   // ********
   task automatic chk(input logic ok, input string what);
      comparisons++;
      if (!ok) begin
         n_fail++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask

   task automatic give_verdict;
      $display("Counts: %0d failed of %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Response taken at the edge that completes the access
   always @(posedge mclk) begin
      if (doe_n === 1'b0) begin
         drove = 1'b1;
      end
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
         e_now = exp_q.pop_front();
         chk(pslverr === e_now.e, "bus response");
         if (!e_now.wr) begin
            chk(prdata === e_now.d, "read data");
         end
      end
   end

   always @(posedge sclk) begin
      if (!rst && $realtime - t_rise < 200.0) begin
         chk($realtime - t_rise == 120.0, "bit period");
      end
      t_rise = $realtime;
      n_rise++;
   end

   // ********
   // Bus master
   // ********
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, input logic [31:0] ed, input logic ee);
      exp_q.push_back('{wr, ed, ee});
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      // Request held until ready is seen at a rising edge
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d);
      apb(1'b0, a, 32'h0, d, 1'b0);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 150) begin
         @(negedge mclk);
         n++;
      end
      chk(n < 150, "interrupt missing");
   endtask

   initial begin
      #300000;
      chk(1'b0, "watchdog");
      give_verdict();
   end

   initial begin
      void'($urandom(32'h557a86e3));
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      idle(1);
      chk(sclk === 1'b1 && doe_n === 1'b1 && irq === 1'b0, "idle");
      rd(A_CTRL, 32'h0);
      rd(A_MASK, 32'h0);
      rd(A_STAT, 32'h0);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h010, 32'hffffffff, 32'h0, 1'b1);
      // Masked transmit, then a refused second start
      b = 8'($urandom);
      n_rise = 0;
      wr(A_BUF, {24'h0, b});
      idle(110);
      chk(irq === 1'b0 && n_rise == 8, "masked frame");
      chk(obyte === b, "sent byte");
      rd(A_STAT, 32'h2);
      rd(A_CTRL, 32'h2);
      n_rise = 0;
      wr(A_BUF, {24'h0, ~b});
      idle(110);
      chk(n_rise == 0 && obyte === b, "start while flag set");
      wr(A_MASK, 32'h3);
      idle(2);
      chk(irq === 1'b1, "unmasked");
      wr(A_STAT, 32'h2);
      wr(A_CTRL, 32'h0);
      idle(2);
      chk(irq === 1'b0, "cleared");
      for (int i = 0; i < 2; i++) begin
         b = 8'($urandom);
         drove = 1'b0;
         wr(A_BUF, {24'h0, b});
         wait_irq();
         chk(obyte === b && drove === 1'b1, "sent byte");
         wr(A_STAT, 32'h2);
         wr(A_CTRL, 32'h0);
      end
      // Reception from the input expander
      clk_dis <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         par <= 8'($urandom);
         @(posedge mclk);
         load_n <= 1'b0;
         @(posedge mclk);
         load_n <= 1'b1;
         n_rise = 0;
         drove = 1'b0;
         wr(A_CTRL, 32'h10);
         wait_irq();
         chk(drove === 1'b0 && n_rise == 8, "receive frame");
         rd(A_CTRL, 32'h11);
         rd(A_BUF, {24'h0, par});
         n_rise = 0;
         wr(A_CTRL, 32'h11);
         idle(110);
         chk(n_rise == 0, "start while flag set");
         wr(A_CTRL, 32'h0);
         wr(A_STAT, 32'h1);
         idle(2);
         chk(irq === 1'b0, "cleared");
      end
      // Other modes and reserved bits
      n_rise = 0;
      wr(A_CTRL, 32'hd0);
      wr(A_BUF, 32'h0000_005a);
      idle(110);
      chk(n_rise == 0, "other mode idle");
      rd(A_CTRL, 32'hd0);
      wr(A_CTRL, 32'h2c);
      rd(A_CTRL, 32'h0);
      idle(4);
      give_verdict();
   end
endmodule
